// ### design/srm_self_refresh_rfm.sv
// Self refresh state, internal refresh, abort and per-bank activate count tracking
`timescale 1ns/10ps
module srm_self_refresh_rfm #(
  parameter int NB = srm_pkg::NUM_BANKS,
  parameter int W = srm_pkg::ACT_COUNT_WIDTH,
  parameter int DENSITY_GB = srm_pkg::DENSITY_GB,
  parameter int EXIT_NS = srm_pkg::EXIT_DELAY_NS,
  parameter int PB_REF_NS = srm_pkg::PB_REFRESH_NS,
  parameter int INT_REF_NS = srm_pkg::INT_REF_INTERVAL_NS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Command bus from the controller
  input wire logic cke,
  input wire logic chipSelect,
  input wire logic [5:0] ca,
  // Configuration
  input wire logic abortEnable,
  input wire logic mgmtRequired,
  input wire logic [W-1:0] initMgmtThreshold,
  input wire logic [2:0] thresholdMultiplier,
  input wire logic [2:0] decrementHalves,
  // Status
  output logic inSelfRefresh,
  output logic inPowerDown,
  output logic exitBusy,
  output logic illegalCmd,
  output logic internalRefresh,
  output logic mgmtCmdSeen,
  output logic [srm_pkg::TIMER_WIDTH-1:0] refreshCounter,
  output logic [NB*W-1:0] rollingActivateCount,
  output logic [NB-1:0] mgmtLimitReached
);
  localparam int BW = (NB > 1) ? $clog2(NB) : 1;
  localparam int TW = srm_pkg::TIMER_WIDTH;
  localparam logic [TW-1:0] EXIT_CYC = TW'(srm_pkg::srm_cycles_up(EXIT_NS * 1000));
  localparam logic [TW-1:0] PB_REF_CYC = TW'(srm_pkg::srm_cycles_up(PB_REF_NS * 1000));
  localparam logic [TW-1:0] ABORT_CYC =
    TW'(srm_pkg::srm_cycles_up(PB_REF_NS * 1000 + srm_pkg::ABORT_MARGIN_PS));
  localparam logic [TW-1:0] INT_REF_CYC = TW'(srm_pkg::srm_cycles_up(INT_REF_NS * 1000));
  localparam logic ABORT_CAPABLE = (DENSITY_GB >= srm_pkg::ABORT_MIN_DENSITY_GB);

  typedef struct packed {
    srm_pkg::srm_mode_t mode;
    logic firstSeen;
    logic [4:0] firstOp;
    logic firstAllBank;
    logic [TW-1:0] exitCnt;
    logic [TW-1:0] refTimer;
    logic [TW-1:0] refBusy;
    logic [TW-1:0] refCount;
    logic illegal;
    logic intRefPulse;
    logic mgmtPulse;
    logic [NB-1:0][W-1:0] actCount;
    logic [NB-1:0] limitHit;
    logic srFlag;
    logic pdFlag;
    logic busyFlag;
  } srm_state_t;

  srm_state_t s;
  srm_state_t next_s;

  // Next state: command decode, self refresh modes, internal refresh, bank counts
  always_comb begin
    logic restricted;
    logic doAct;
    logic doRef;
    logic doRfm;
    logic allBank;
    logic [BW-1:0] bank;
    logic [2*W-1:0] maxT;
    logic [2*W-1:0] decRfm;
    logic [2*W-1:0] cur;
    logic hit;
    restricted = 1'b0;
    doAct = 1'b0;
    doRef = 1'b0;
    doRfm = 1'b0;
    allBank = 1'b0;
    bank = BW'(ca[2:0]);
    maxT = (2*W)'(initMgmtThreshold) * (2*W)'(thresholdMultiplier);
    decRfm = ((2*W)'(initMgmtThreshold) * (2*W)'(decrementHalves)) >> 1;
    cur = '0;
    hit = 1'b0;
    next_s = s;
    next_s.illegal = 1'b0;
    next_s.intRefPulse = 1'b0;
    next_s.mgmtPulse = 1'b0;
    restricted = (s.mode != srm_pkg::MODE_ACTIVE) || (s.exitCnt != '0);

    // Exit window countdown
    if (s.exitCnt != '0) begin
      next_s.exitCnt = s.exitCnt - 1'b1;
    end

    // Power-down nests inside self refresh; the command bus is dead while cke is low
    if (s.mode == srm_pkg::MODE_SR && !cke) begin
      next_s.mode = srm_pkg::MODE_SR_PD; // [R9]
      next_s.firstSeen = 1'b0;
    end else if (s.mode == srm_pkg::MODE_SR_PD) begin
      if (cke) begin
        next_s.mode = srm_pkg::MODE_SR; // [R9]
      end
    end else if (cke && s.firstSeen && !chipSelect) begin
      // Second edge: chip select low, CA carries the operands
      next_s.firstSeen = 1'b0;
      case (s.firstOp)
        srm_pkg::OP_SRE: begin
          // Entry taken only from the active mode and outside the exit window
          if (restricted) begin
            next_s.illegal = 1'b1;
          end else begin
            next_s.mode = srm_pkg::MODE_SR; // [R1] [R2]
          end
        end
        srm_pkg::OP_SRX: begin
          if (s.mode == srm_pkg::MODE_SR) begin
            next_s.mode = srm_pkg::MODE_ACTIVE;
            // Abort only on dense enough parts; smaller ones ignore the bit
            if (abortEnable && ABORT_CAPABLE) begin // [R14]
              next_s.exitCnt = ABORT_CYC; // [R12]
              next_s.refBusy = '0; // [R11]
            end else begin
              next_s.exitCnt = EXIT_CYC;
            end
          end else begin
            next_s.illegal = 1'b1;
          end
        end
        srm_pkg::OP_REF: begin
          if (restricted) begin
            next_s.illegal = 1'b1;
          end else begin
            allBank = s.firstAllBank;
            if (mgmtRequired && ca[srm_pkg::CA_RFM_BIT]) begin
              doRfm = 1'b1; // [R20]
              next_s.mgmtPulse = 1'b1;
            end else begin
              doRef = 1'b1;
            end
          end
        end
        srm_pkg::OP_MRW1: begin
          // Mask and abort settings must stay frozen across self refresh
          if (restricted && (ca == srm_pkg::MA_ABORT || ca == srm_pkg::MA_PASR_BANK ||
                             ca == srm_pkg::MA_PASR_SEG)) begin
            next_s.illegal = 1'b1; // [R4] [R6]
          end
        end
        srm_pkg::OP_MRW2, srm_pkg::OP_MRR1, srm_pkg::OP_CAS2, srm_pkg::OP_MPC: begin
          next_s.illegal = 1'b0; // [R4] [R6]
        end
        default: begin
          if (restricted) begin
            next_s.illegal = 1'b1; // [R4] [R6]
          end else if (s.firstOp[1:0] == srm_pkg::OP_ACT1_LOW) begin
            doAct = 1'b1; // [R21]
          end
        end
      endcase
    end else if (cke && chipSelect) begin
      // First edge; a second high edge simply restarts the pair
      next_s.firstSeen = 1'b1;
      next_s.firstOp = ca[4:0];
      next_s.firstAllBank = ca[srm_pkg::CA_ALLBANK_BIT];
    end

    // Internal refresh timer runs in self refresh and its power-down alike
    if (s.mode != srm_pkg::MODE_ACTIVE) begin
      if (s.refTimer <= 1) begin
        next_s.refTimer = INT_REF_CYC; // [R3] [R9]
        // The exit edge itself never starts a fresh refresh, so an abort leaves nothing running
        if (s.refBusy == '0 && next_s.mode != srm_pkg::MODE_ACTIVE) begin
          next_s.refBusy = PB_REF_CYC;
          next_s.intRefPulse = 1'b1;
        end
      end else begin
        next_s.refTimer = s.refTimer - 1'b1;
      end
    end else begin
      next_s.refTimer = INT_REF_CYC;
    end

    // A refresh left running after a normal exit completes and advances the counter
    if (s.refBusy != '0 && next_s.refBusy != '0 && !next_s.intRefPulse) begin
      next_s.refBusy = s.refBusy - 1'b1;
      if (s.refBusy == 1) begin
        next_s.refCount = s.refCount + 1'b1; // [R3]
      end
    end

    // Bank counts move only on activate, refresh and management commands
    for (int b = 0; b < NB; b++) begin
      hit = allBank || (bank == BW'(b));
      cur = (2*W)'(s.actCount[b]);
      if (doAct && hit && cur < maxT) begin
        next_s.actCount[b] = s.actCount[b] + 1'b1; // [R24]
      end else if (doRef && hit) begin
        next_s.actCount[b] = (cur > (2*W)'(initMgmtThreshold)) ?
          W'(cur - (2*W)'(initMgmtThreshold)) : '0; // [R17] [R22]
      end else if (doRfm && hit) begin
        next_s.actCount[b] = (cur > decRfm) ? W'(cur - decRfm) : '0; // [R16] [R22]
      end
      // Self refresh entry and exit never touch the counts
      next_s.limitHit[b] = ((2*W)'(next_s.actCount[b]) >= maxT) && (maxT != '0); // [R23]
    end

    // Status levels are registered so no output passes through decode gates
    next_s.srFlag = (next_s.mode != srm_pkg::MODE_ACTIVE);
    next_s.pdFlag = (next_s.mode == srm_pkg::MODE_SR_PD);
    next_s.busyFlag = (next_s.exitCnt != '0);
  end

  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register
  assign inSelfRefresh = s.srFlag;
  assign inPowerDown = s.pdFlag;
  assign exitBusy = s.busyFlag;
  assign illegalCmd = s.illegal;
  assign internalRefresh = s.intRefPulse;
  assign mgmtCmdSeen = s.mgmtPulse;
  assign refreshCounter = s.refCount;
  assign rollingActivateCount = s.actCount;
  assign mgmtLimitReached = s.limitHit;
endmodule

// ### design/srm_pkg.sv
// Constants, opcodes and timing for the self refresh and refresh management block
//
// Behaviour
// (R1) Self refresh entry is a two-edge command
// (R2) Entry only when idle, bursts finished
// (R3) Internal timer refreshes while in self refresh
// (R4) In self refresh only listed commands accepted
// (R5) Host keeps minimum self refresh residency
// (R6) Exit window allows only listed commands
// (R7) One extra refresh after each exit
// (R8) Extra refresh outside regular refresh accounting
// (R9) Power-down allowed inside self refresh
// (R10) Clock changes only during power-down
// (R11) Abort cancels ongoing refresh, counter held
// (R12) Abort shortens exit delay by margin; the code sets it to per-bank refresh plus margin, 22 cycles instead of 56
// (R13) Extra refresh needed regardless of abort
// (R14) Abort only at 6 Gb or more
// (R15) Host refreshes bank at maximum threshold
// (R16) Management refresh lowers count by threshold times factor
// (R17) Ordinary refresh lowers count by threshold
// (R18) No management needed below threshold or fast refresh
// (R19) Host should manage banks nearing maximum
// (R20) CA3 high selects management; CA5 selects all
// (R21) Each activate adds one to bank count
// (R22) Count never below zero, no credit
// (R23) Self refresh leaves counts unchanged
// (R24) Saturating counter per bank, eight banks
package srm_pkg;
  // Clock and timing figures
  localparam int CLK_PERIOD_PS = 5000;
  localparam int EXIT_DELAY_NS = 280;
  localparam int PB_REFRESH_NS = 90;
  localparam int ABORT_MARGIN_PS = 17500;
  localparam int INT_REF_INTERVAL_NS = 3904;

  // Bank layout and density
  localparam int NUM_BANKS = 8;
  localparam int ACT_COUNT_WIDTH = 11;
  localparam int DENSITY_GB = 16;
  localparam int ABORT_MIN_DENSITY_GB = 6;
  localparam int TIMER_WIDTH = 16;

  // First-edge opcodes on CA4..CA0, chip select high
  localparam logic [4:0] OP_SRE = 5'h18;
  localparam logic [4:0] OP_SRX = 5'h0A;
  localparam logic [4:0] OP_REF = 5'h08;
  localparam logic [4:0] OP_MPC = 5'h00;
  localparam logic [4:0] OP_MRW1 = 5'h06;
  localparam logic [4:0] OP_MRW2 = 5'h16;
  localparam logic [4:0] OP_MRR1 = 5'h0E;
  localparam logic [4:0] OP_CAS2 = 5'h12;
  localparam logic [1:0] OP_ACT1_LOW = 2'h1;

  // CA field positions
  localparam int CA_RFM_BIT = 3;
  localparam int CA_ALLBANK_BIT = 5;

  // Mode registers that may not be written in or just after self refresh
  localparam logic [5:0] MA_ABORT = 6'h04;
  localparam logic [5:0] MA_PASR_BANK = 6'h10;
  localparam logic [5:0] MA_PASR_SEG = 6'h11;

  typedef enum logic [1:0] {MODE_ACTIVE, MODE_SR, MODE_SR_PD} srm_mode_t;

  // Least time in picoseconds to whole cycles, never below one
  function automatic int srm_cycles_up(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    srm_cycles_up = (c < 1) ? 1 : c;
  endfunction
endpackage

// ### sim/srm_properties.sv
// Checker for self refresh, exit window and activate count behaviour
`timescale 1ns/10ps
module srm_properties #(
  parameter int NB = 8,
  parameter int W = 11,
  parameter int DENSITY_GB = 16,
  parameter int EXIT_NS = 280,
  parameter int PB_REF_NS = 90
) (
  // Clock, reset and command bus
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cke,
  input wire logic chipSelect,
  input wire logic [5:0] ca,
  // Configuration
  input wire logic abortEnable,
  input wire logic mgmtRequired,
  input wire logic [W-1:0] initMgmtThreshold,
  input wire logic [2:0] decrementHalves,
  // Status
  input wire logic inSelfRefresh,
  input wire logic inPowerDown,
  input wire logic exitBusy,
  input wire logic illegalCmd,
  input wire logic internalRefresh,
  input wire logic mgmtCmdSeen,
  input wire logic [srm_pkg::TIMER_WIDTH-1:0] refreshCounter,
  input wire logic [NB*W-1:0] rollingActivateCount
);
  localparam int EXIT_CYC = (EXIT_NS * 1000 + 4999) / 5000;
  localparam int ABORT_CYC = (PB_REF_NS * 1000 + 17500 + 4999) / 5000;
  logic pend;
  logic [4:0] op;
  logic [7:0] busyCnt;
  logic cmdB, free;
  logic [W-1:0] c0, dec;
  assign cmdB = cke && !chipSelect && pend;
  assign free = !inSelfRefresh && !exitBusy;
  assign c0 = rollingActivateCount[W-1:0];
  assign dec = (mgmtRequired && ca[3]) ? W'((32'(initMgmtThreshold) * 32'(decrementHalves)) / 2) :
    initMgmtThreshold;
  // First-edge capture; power-down drops a half-sent command, as the device does
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pend <= 1'b0;
      op <= 5'h00;
      busyCnt <= 8'h00;
    end else begin
      pend <= cke && chipSelect && !inPowerDown;
      if (cke && chipSelect) begin
        op <= ca[4:0];
      end
      busyCnt <= exitBusy ? busyCnt + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  refresh_in_sr_a: assert property (internalRefresh |-> inSelfRefresh || $past(inSelfRefresh))
    else $error("internal refresh started outside self refresh");
  act_refused_a: assert property (inSelfRefresh && !inPowerDown && cmdB && op[1:0] == 2'h1 |=> illegalCmd)
    else $error("activate in self refresh not refused");
  pd_entry_a: assert property (inSelfRefresh && !cke |=> inPowerDown && inSelfRefresh)
    else $error("power-down entry inside self refresh missed");
  pd_exit_a: assert property (inPowerDown && cke |=> !inPowerDown && inSelfRefresh)
    else $error("power-down exit inside self refresh missed");
  exit_length_a: assert property ($fell(exitBusy) |->
    busyCnt == ((abortEnable && DENSITY_GB >= 6) ? ABORT_CYC : EXIT_CYC))
    else $error("exit window length wrong");
  abort_hold_a: assert property (exitBusy && $past(exitBusy) && abortEnable && DENSITY_GB >= 6
    |-> $stable(refreshCounter))
    else $error("refresh counter moved after abort");
  count_lower_a: assert property (cmdB && op == srm_pkg::OP_REF && ca[2:0] == 3'h0 && free
    |=> c0 == (($past(c0) > $past(dec)) ? W'($past(c0) - $past(dec)) : '0))
    else $error("bank count not lowered correctly");
  mgmt_pulse_a: assert property (cmdB && op == srm_pkg::OP_REF && free
    |=> mgmtCmdSeen == ($past(mgmtRequired) && $past(ca[3])))
    else $error("management decode wrong");
  counts_kept_a: assert property ($changed(inSelfRefresh) |-> $stable(rollingActivateCount))
    else $error("bank counts changed at self refresh edge");
  cover property (cmdB && op == srm_pkg::OP_SRE && free);
  cover property ($fell(exitBusy) && abortEnable);
  cover property (mgmtCmdSeen);
endmodule
bind srm_self_refresh_rfm srm_properties #(.NB(NB), .W(W), .DENSITY_GB(DENSITY_GB), .EXIT_NS(EXIT_NS),
  .PB_REF_NS(PB_REF_NS)) chk (.ref_clk(ref_clk), .nrst(nrst), .cke(cke), .chipSelect(chipSelect), .ca(ca),
  .abortEnable(abortEnable), .mgmtRequired(mgmtRequired), .initMgmtThreshold(initMgmtThreshold),
  .decrementHalves(decrementHalves), .inSelfRefresh(inSelfRefresh), .inPowerDown(inPowerDown),
  .exitBusy(exitBusy), .illegalCmd(illegalCmd), .internalRefresh(internalRefresh), .mgmtCmdSeen(mgmtCmdSeen),
  .refreshCounter(refreshCounter), .rollingActivateCount(rollingActivateCount));

// ### sim/srm_ctrl_model.sv
// Memory controller model driving the two-edge command bus
`timescale 1ns/10ps
module srm_ctrl_model (
  // Clock
  input wire logic ref_clk,
  // Command bus
  output logic cke,
  output logic chipSelect,
  output logic [5:0] ca
);
  initial begin
    cke = 1'b1;
    chipSelect = 1'b0;
    ca = 6'h00;
  end
  // Two-edge command; CA is scrambled after sampling so stale values never look valid
  task automatic issue(input logic [5:0] a, input logic [5:0] b);
    @(posedge ref_clk);
    chipSelect <= 1'b1;
    ca <= a;
    @(posedge ref_clk);
    chipSelect <= 1'b0;
    ca <= b;
    @(posedge ref_clk);
    ca <= ~b;
  endtask
  // Power-down; the clock never stops here, the safe choice for any wake timing
  task automatic nap(input int n);
    @(posedge ref_clk);
    cke <= 1'b0;
    repeat (n) @(posedge ref_clk);
    cke <= 1'b1;
  endtask
endmodule

// ### sim/self_refresh_and_rfm_tracking_bench.sv
// Self-checking bench with a behavioural bank count model
`timescale 1ns/10ps
module self_refresh_and_rfm_tracking_bench;
  localparam int W = 11;
  localparam int IMT = 20;
  localparam int MAXT = 80;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cke, chipSelect, abortEnable, mgmtRequired, inSelfRefresh, inPowerDown, exitBusy, illegalCmd;
  logic internalRefresh, mgmtCmdSeen;
  logic [5:0] ca;
  logic [W-1:0] initMgmtThreshold;
  logic [2:0] thresholdMultiplier, decrementHalves;
  logic [15:0] refreshCounter;
  logic [8*W-1:0] rollingActivateCount;
  logic [7:0] mgmtLimitReached;
  int err_count = 0;
  int cmp_count = 0;
  int seed = 69299;
  int cnt[8];
  int n, snap;
  always #2.5 ref_clk = ~ref_clk;
  srm_ctrl_model ctl (.ref_clk(ref_clk), .cke(cke), .chipSelect(chipSelect), .ca(ca));
  // Short internal refresh interval keeps the run brief
  srm_self_refresh_rfm #(.INT_REF_NS(100)) uut (.ref_clk(ref_clk), .nrst(nrst), .cke(cke),
    .chipSelect(chipSelect), .ca(ca), .abortEnable(abortEnable), .mgmtRequired(mgmtRequired),
    .initMgmtThreshold(initMgmtThreshold), .thresholdMultiplier(thresholdMultiplier),
    .decrementHalves(decrementHalves), .inSelfRefresh(inSelfRefresh), .inPowerDown(inPowerDown),
    .exitBusy(exitBusy), .illegalCmd(illegalCmd), .internalRefresh(internalRefresh), .mgmtCmdSeen(mgmtCmdSeen),
    .refreshCounter(refreshCounter), .rollingActivateCount(rollingActivateCount),
    .mgmtLimitReached(mgmtLimitReached));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Every bank count and limit flag against the model
  task automatic check_all;
    for (int b = 0; b < 8; b++) begin
      check(rollingActivateCount[b*W +: W], cnt[b]);
      check(mgmtLimitReached[b], cnt[b] >= MAXT);
    end
  endtask
  // One command and the refusal flag one cycle after its second edge
  task automatic try_cmd(input logic [5:0] a, input logic [5:0] b, input logic exp);
    ctl.issue(a, b);
    #1 check(illegalCmd, exp);
  endtask
  task automatic act(input int b);
    ctl.issue(6'h01, 6'(b));
    if (cnt[b] < MAXT) cnt[b]++;
  endtask
  // Refresh or management refresh; the model floors at zero
  task automatic refr(input int b, input logic ab, input logic rfm);
    int dec;
    ctl.issue({ab, srm_pkg::OP_REF}, {2'h0, rfm, 3'(b)});
    dec = (rfm && mgmtRequired) ? IMT * decrementHalves / 2 : IMT;
    for (int i = 0; i < 8; i++) if (ab || i == b) cnt[i] = (cnt[i] > dec) ? cnt[i] - dec : 0;
    #1 check(mgmtCmdSeen, rfm && mgmtRequired);
    check_all();
  endtask
  // Length of the exit window, bounded so a stuck flag ends the run
  task automatic exit_len(input int exp);
    n = 0;
    while (exitBusy === 1'b1) begin
      n++;
      if (n > 200) begin
        err_count++;
        summarize();
      end
      @(posedge ref_clk) #1;
    end
    check(n, exp);
  endtask
  initial begin
    abortEnable = 1'b0;
    mgmtRequired = 1'b0;
    initMgmtThreshold = 11'(IMT);
    thresholdMultiplier = 3'h4;
    decrementHalves = 3'h4;
    cnt = '{default: 0};
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 40; i++) act($random(seed) & 7);
    for (int i = 0; i < 90; i++) act(2);
    #1 check_all();
    $display("test activate done");
    // Every refresh kind, both decrement factors, and management flag off
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      mgmtRequired <= (i < 4);
      decrementHalves <= i[0] ? 3'h3 : 3'h4;
      refr(i, i[0], i[1] | i[2]);
    end
    $display("test refresh done");
    ctl.issue({1'b0, srm_pkg::OP_SRE}, 6'h00);
    #1 check(inSelfRefresh, 1'b1);
    ctl.issue(6'h01, 6'h02);
    #1 check(illegalCmd, 1'b1);
    ctl.issue({1'b0, srm_pkg::OP_MRW1}, srm_pkg::MA_ABORT);
    #1 check(illegalCmd, 1'b1);
    ctl.issue({1'b0, srm_pkg::OP_MPC}, 6'h00);
    #1 check(illegalCmd, 1'b0);
    // Remaining allowed commands pass; a segment mask write and a second entry are refused
    try_cmd({1'b0, srm_pkg::OP_MRW2}, 6'h00, 1'b0);
    try_cmd({1'b0, srm_pkg::OP_MRR1}, 6'h00, 1'b0);
    try_cmd({1'b0, srm_pkg::OP_CAS2}, 6'h00, 1'b0);
    try_cmd({1'b0, srm_pkg::OP_MRW1}, 6'h01, 1'b0);
    try_cmd({1'b0, srm_pkg::OP_MRW1}, srm_pkg::MA_PASR_SEG, 1'b1);
    try_cmd({1'b0, srm_pkg::OP_SRE}, 6'h00, 1'b1);
    ctl.nap(60);
    #1 check(inPowerDown, 1'b1);
    repeat (60) @(posedge ref_clk);
    #1 check(refreshCounter != 16'h0000, 1'b1);
    check(inPowerDown, 1'b0);
    check(inSelfRefresh, 1'b1);
    ctl.issue({1'b0, srm_pkg::OP_SRX}, 6'h00);
    #1 check(inSelfRefresh, 1'b0);
    // Inside the exit window an activate and a mask write are refused
    try_cmd(6'h01, 6'h03, 1'b1);
    try_cmd({1'b0, srm_pkg::OP_MRW1}, srm_pkg::MA_PASR_BANK, 1'b1);
    // The two commands above used six of the window's cycles
    exit_len((280 * 1000 + 4999) / 5000 - 6);
    check_all();
    refr(0, 1'b1, 1'b0);
    $display("test self refresh done");
    @(posedge ref_clk);
    abortEnable <= 1'b1;
    ctl.issue({1'b0, srm_pkg::OP_SRE}, 6'h00);
    repeat (47) @(posedge ref_clk);
    ctl.issue({1'b0, srm_pkg::OP_SRX}, 6'h00);
    #1 snap = refreshCounter;
    exit_len((90 * 1000 + 17500 + 4999) / 5000);
    check(refreshCounter, snap);
    refr(0, 1'b1, 1'b0);
    try_cmd({1'b0, srm_pkg::OP_SRX}, 6'h00, 1'b1);
    $display("test abort done");
    summarize();
  end
endmodule
